// [hw/bitaddr_map.svh]
`ifndef BITADDR_MAP_SVH
`define BITADDR_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RBA_CMD_OFF 8'h00
`define RBA_TEMP_OFF 8'h04
`define RBA_CFG_OFF 8'h08
`define RBA_STAT_OFF 8'h0C
`define RBA_ADDR_OFF 8'h10
`define RBA_ACCLO_OFF 8'h14
`define RBA_ACCHI_OFF 8'h18
`define RBA_PTR_BASE 8'h20
`define RBA_BSA_BASE 8'h40
`define RBA_BANK_MASK 8'hE0

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define RBA_OP_BIT 0
`define RBA_FORM_LSB 1
`define RBA_PTR_LSB 3
`define RBA_PAR_BIT 6

// ----------------------------------------
// status fields
// ----------------------------------------
`define RBA_TC1_BIT 0
`define RBA_TC2_BIT 1
`define RBA_REFUSED_BIT 2
`define RBA_EXTWAIT_BIT 3

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define RBA_ACC_BITS 40
`define RBA_PTR_RST 23'h000000
`define RBA_BSA_RST 16'h0000
`define RBA_T1_RST 16'h0000
`define RBA_ACC_RST 40'h0000000000

`endif

// [hw/bitaddr_pkg.sv]
package bitaddr_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_ext = 3'b010,
    st_exec = 3'b100
  } seq_e;

  typedef enum logic [1:0] {
    form_post_inc = 2'h0,
    form_post_dec = 2'h1,
    form_idx_reg = 2'h2,
    form_idx_const = 2'h3
  } form_e;

  typedef enum logic {
    bit_clear_op = 1'b0,
    bit_pair_test_op = 1'b1
  } bitop_e;

  typedef struct packed {
    logic par;
    logic [2:0] ptr;
    form_e form;
    bitop_e op;
  } instr_s;

  typedef struct packed {
    logic [22:0] addr;
    logic [22:0] next_ptr;
    logic write_ptr;
  } addr_res_s;

  typedef struct packed {
    seq_e seq;
    instr_s instr;
    logic [15:0] k16;
    logic [7:0][22:0] ptr;
    logic [7:0][15:0] bsa;
    logic [7:0] circ;
    logic [15:0] t1;
    logic [39:0] acc;
    logic tc1;
    logic tc2;
    logic refused;
    logic [22:0] last_addr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

endpackage

// [hw/bit_addr_unit.sv]
`timescale 1ns/1ps
`include "bitaddr_map.svh"

module bit_addr_unit
  import bitaddr_pkg::*;
(
  input wire logic [22:0] extended_aux_pointer,
  input wire logic [15:0] buffer_start_reg,
  input wire logic circular,
  input wire logic [15:0] temp_offset_reg,
  input wire logic [15:0] signed_offset_const,
  input wire form_e form,
  output addr_res_s res
);

  function automatic logic [22:0] sext16(input logic [15:0] v);
    sext16 = {{7{v[15]}}, v};
  endfunction

  logic [22:0] base;

  always_comb begin
    // buffer start joins only for a circular pointer
    base = circular ? extended_aux_pointer + sext16(buffer_start_reg) : extended_aux_pointer;
    res.addr = base;
    res.next_ptr = extended_aux_pointer;
    res.write_ptr = 1'b0;
    unique case (form)
      form_post_inc: begin
        res.next_ptr = extended_aux_pointer + sext16(temp_offset_reg);
        res.write_ptr = 1'b1;
      end
      form_post_dec: begin
        res.next_ptr = extended_aux_pointer - sext16(temp_offset_reg);
        res.write_ptr = 1'b1;
      end
      form_idx_reg: begin
        res.addr = base + sext16(temp_offset_reg);
      end
      form_idx_const: begin
        res.addr = base + sext16(signed_offset_const);
      end
    endcase
  end

endmodule // bit_addr_unit

// [hw/register_bit_address_generator.sv]
// Behaviour
// - post-increment: use pointer, then add offset
// - post-decrement: use pointer, then subtract offset
// - register index: pointer plus offset, unchanged
// - constant index: pointer plus sign-extended constant, pointer unchanged
// - constant taken from following extension word
// - constant form never runs in parallel
// - pair test: addressed bit to flag one
// - pair test: next bit to flag two
// - clear: zero only the addressed bit
// - address is pointer plus optional buffer start
// - buffer start sign-extended when circular
`timescale 1ns/1ps
`include "bitaddr_map.svh"

module register_bit_address_generator
  import bitaddr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic test_flag_one,
  output logic test_flag_two,
  output logic [39:0] accumulator_two
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if ((a & `RBA_BANK_MASK) == `RBA_PTR_BASE) begin
      hit = (a[1:0] == 2'b00);
    end else if ((a & `RBA_BANK_MASK) == `RBA_BSA_BASE) begin
      hit = (a[1:0] == 2'b00);
    end else begin
      hit = (a == `RBA_CMD_OFF) || (a == `RBA_TEMP_OFF) || (a == `RBA_CFG_OFF) ||
            (a == `RBA_STAT_OFF) || (a == `RBA_ADDR_OFF) || (a == `RBA_ACCLO_OFF) ||
            (a == `RBA_ACCHI_OFF);
    end
    is_mapped = hit;
  endfunction

  function automatic logic [2:0] bank_slot(input logic [7:0] a);
    bank_slot = a[4:2];
  endfunction

  // reads beyond the accumulator width give zero
  function automatic logic acc_bit(input logic [39:0] acc, input logic [5:0] pos);
    logic b;
    b = 1'b0;
    if (pos < 6'(`RBA_ACC_BITS)) begin
      b = acc[pos];
    end
    acc_bit = b;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  state_s s_q;
  state_s s_d;
  addr_res_s res;
  logic [5:0] pos;
  logic [5:0] pos_next;
  logic setup;
  logic access;
  logic [31:0] rd;
  instr_s new_instr;

  bit_addr_unit u_calc (
    .extended_aux_pointer(s_q.ptr[s_q.instr.ptr]),
    .buffer_start_reg(s_q.bsa[s_q.instr.ptr]),
    .circular(s_q.circ[s_q.instr.ptr]),
    .temp_offset_reg(s_q.t1),
    .signed_offset_const(s_q.k16),
    .form(s_q.instr.form),
    .res(res)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    setup = psel & ~penable;
    access = psel & penable & s_q.pready;
    pos = res.addr[5:0];
    pos_next = 6'(res.addr[5:0] + 6'h01);
    new_instr = instr_s'(pwdata[6:0]);
    rd = 32'h00000000;

    // zero-wait slave: ready in the first access cycle
    s_d.pready = setup;
    s_d.pslverr = setup & ~is_mapped(paddr);

    if (setup) begin
      if ((paddr & `RBA_BANK_MASK) == `RBA_PTR_BASE) begin
        rd = {9'h000, s_q.ptr[bank_slot(paddr)]};
      end else if ((paddr & `RBA_BANK_MASK) == `RBA_BSA_BASE) begin
        rd = {16'h0000, s_q.bsa[bank_slot(paddr)]};
      end else begin
        unique case (paddr)
          `RBA_CMD_OFF: rd = {25'h0000000, s_q.instr};
          `RBA_TEMP_OFF: rd = {16'h0000, s_q.t1};
          `RBA_CFG_OFF: rd = {24'h000000, s_q.circ};
          `RBA_STAT_OFF: begin
            rd[`RBA_TC1_BIT] = s_q.tc1;
            rd[`RBA_TC2_BIT] = s_q.tc2;
            rd[`RBA_REFUSED_BIT] = s_q.refused;
            rd[`RBA_EXTWAIT_BIT] = (s_q.seq == st_ext);
          end
          `RBA_ADDR_OFF: rd = {9'h000, s_q.last_addr};
          `RBA_ACCLO_OFF: rd = s_q.acc[31:0];
          `RBA_ACCHI_OFF: rd = {24'h000000, s_q.acc[39:32]};
          default: rd = 32'h00000000;
        endcase
      end
      s_d.prdata = rd;
    end

    if (access && pwrite) begin
      if ((paddr & `RBA_BANK_MASK) == `RBA_PTR_BASE) begin
        s_d.ptr[bank_slot(paddr)] = pwdata[22:0];
      end else if ((paddr & `RBA_BANK_MASK) == `RBA_BSA_BASE) begin
        s_d.bsa[bank_slot(paddr)] = pwdata[15:0];
      end else begin
        unique case (paddr)
          `RBA_CMD_OFF: begin
            if (s_q.seq == st_ext) begin
              // word after a constant-form instruction is its offset
              s_d.k16 = pwdata[15:0];
              s_d.seq = st_exec;
            end else if (s_q.seq == st_idle) begin
              if (new_instr.form == form_idx_const && new_instr.par) begin
                // constant form cannot share the slot with another instruction
                s_d.refused = 1'b1;
              end else begin
                s_d.instr = new_instr;
                s_d.seq = (new_instr.form == form_idx_const) ? st_ext : st_exec;
              end
            end
          end
          `RBA_TEMP_OFF: s_d.t1 = pwdata[15:0];
          `RBA_CFG_OFF: s_d.circ = pwdata[7:0];
          `RBA_STAT_OFF: begin
            if (pwdata[`RBA_REFUSED_BIT]) begin
              s_d.refused = 1'b0;
            end
          end
          `RBA_ACCLO_OFF: s_d.acc[31:0] = pwdata;
          `RBA_ACCHI_OFF: s_d.acc[39:32] = pwdata[7:0];
          default: begin
          end
        endcase
      end
    end

    // one execute cycle; the next bus write is at least two edges away
    if (s_q.seq == st_exec) begin
      s_d.seq = st_idle;
      s_d.last_addr = res.addr;
      if (res.write_ptr) begin
        s_d.ptr[s_q.instr.ptr] = res.next_ptr;
      end
      if (s_q.instr.op == bit_pair_test_op) begin
        s_d.tc1 = acc_bit(s_q.acc, pos);
        s_d.tc2 = acc_bit(s_q.acc, pos_next);
      end else if (pos < 6'(`RBA_ACC_BITS)) begin
        s_d.acc[pos] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.seq <= st_idle;
      s_q.instr <= instr_s'(7'h00);
      s_q.k16 <= 16'h0000;
      s_q.ptr <= {8{`RBA_PTR_RST}};
      s_q.bsa <= {8{`RBA_BSA_RST}};
      s_q.circ <= 8'h00;
      s_q.t1 <= `RBA_T1_RST;
      s_q.acc <= `RBA_ACC_RST;
      s_q.tc1 <= 1'b0;
      s_q.tc2 <= 1'b0;
      s_q.refused <= 1'b0;
      s_q.last_addr <= 23'h000000;
      s_q.prdata <= 32'h00000000;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign test_flag_one = s_q.tc1;
  assign test_flag_two = s_q.tc2;
  assign accumulator_two = s_q.acc;

endmodule // register_bit_address_generator

// [bench/register_bit_address_generator_asserts.sv]
`timescale 1ns/1ps
`include "bitaddr_map.svh"

module rba_checker
  import bitaddr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic test_flag_one,
  input wire logic test_flag_two,
  input wire logic [39:0] accumulator_two
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cmdw;
  // an instruction executes one edge after its write, so effects trail the write by two samples
  assign cmdw = psel && penable && pwrite && paddr == `RBA_CMD_OFF;
  AST_READY_ONE: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  AST_ERR_MAP: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr == 8'h1C || paddr >= 8'h60))
    else $error("error response on wrong address");
  AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not zero");
  AST_CLEAR_NO_SET: assert property ($past(cmdw, 2) |-> (accumulator_two & ~$past(accumulator_two)) == 40'h0)
    else $error("instruction set an accumulator bit");
  AST_CLEAR_ONE_BIT: assert property ($past(cmdw, 2) |-> $countones(accumulator_two ^ $past(accumulator_two)) <= 1)
    else $error("more than one bit cleared");
  AST_ACC_CAUSE: assert property ($changed(accumulator_two) |-> $past(psel && penable && pwrite) || $past(cmdw, 2))
    else $error("accumulator changed without cause");
  AST_FLAG_CAUSE: assert property ($changed({test_flag_one, test_flag_two}) |-> $past(cmdw, 2))
    else $error("flags changed without instruction");
  cover property (cmdw);
  cover property (pready && pslverr);
  cover property ($rose(test_flag_two));
endmodule // rba_checker

bind register_bit_address_generator rba_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .test_flag_one(test_flag_one), .test_flag_two(test_flag_two),
  .accumulator_two(accumulator_two));

// [bench/test_register_bit_address_generator.sv]
`timescale 1ns/1ps
`include "bitaddr_map.svh"

module test_register_bit_address_generator
  import bitaddr_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, test_flag_one, test_flag_two, er;
  logic [39:0] accumulator_two, ea;
  int n_fail = 0;
  int num_checks = 0;

  register_bit_address_generator i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_flag_one(test_flag_one), .test_flag_two(test_flag_two), .accumulator_two(accumulator_two));

  initial begin
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // no wait count assumed: the loop bound is only a hang guard
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [39:0] e);
    apb(1'b0, a, 32'h0);
    chk({8'h00, rd}, e);
  endtask

  task automatic cmd(input logic [31:0] d);
    apb(1'b1, `RBA_CMD_OFF, d);
    repeat (2) @(posedge pclk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(accumulator_two, 40'h0);
    rdc(`RBA_STAT_OFF, 40'h0);
    apb(1'b0, 8'h60, 32'h0);
    chk({39'h0, er}, 40'h1);
    chk({8'h00, rd}, 40'h0);
    apb(1'b1, 8'h1C, 32'h1234);
    chk({39'h0, er}, 40'h1);
    $display("test reset done");
  endtask

  task automatic t_post();
    apb(1'b1, `RBA_ACCLO_OFF, 32'hFFFFFFFF);
    apb(1'b1, `RBA_ACCHI_OFF, 32'h000000FF);
    apb(1'b1, `RBA_TEMP_OFF, 32'h3);
    ea = 40'hFFFFFFFFFF;
    cmd(32'h00);
    ea[0] = 1'b0;
    chk(accumulator_two, ea);
    rdc(`RBA_PTR_BASE, 40'h3);
    cmd(32'h00);
    ea[3] = 1'b0;
    chk(accumulator_two, ea);
    rdc(`RBA_ADDR_OFF, 40'h3);
    rdc(`RBA_PTR_BASE, 40'h6);
    apb(1'b1, `RBA_ACCLO_OFF, 32'h40000000);
    ea[31:0] = 32'h40000000;
    apb(1'b1, 8'h24, 32'd30);
    cmd(32'h0B);
    chk({38'h0, test_flag_one, test_flag_two}, 40'h2);
    chk(accumulator_two, ea);
    rdc(`RBA_ADDR_OFF, 40'd30);
    rdc(8'h24, 40'd27);
    $display("test post forms done");
  endtask

  task automatic t_index();
    // refill with ones so that every later clear is visible
    apb(1'b1, `RBA_ACCLO_OFF, 32'hFFFFFFFF);
    ea[31:0] = 32'hFFFFFFFF;
    apb(1'b1, `RBA_TEMP_OFF, 32'd15);
    cmd(32'h14);
    ea[15] = 1'b0;
    chk(accumulator_two, ea);
    rdc(8'h28, 40'h0);
    cmd(32'h26);
    rdc(`RBA_STAT_OFF, 40'h9);
    cmd(32'd31);
    ea[31] = 1'b0;
    chk(accumulator_two, ea);
    rdc(8'h30, 40'h0);
    apb(1'b1, 8'h2C, 32'd40);
    cmd(32'h1F);
    cmd(32'hFFF7);
    chk({38'h0, test_flag_one, test_flag_two}, 40'h1);
    rdc(`RBA_ADDR_OFF, 40'd31);
    cmd(32'h66);
    rdc(`RBA_STAT_OFF, 40'h6);
    chk(accumulator_two, ea);
    apb(1'b1, `RBA_STAT_OFF, 32'h4);
    rdc(`RBA_STAT_OFF, 40'h2);
    $display("test index forms done");
  endtask

  task automatic t_circ();
    apb(1'b1, `RBA_CFG_OFF, 32'h20);
    apb(1'b1, 8'h54, 32'hFFFE);
    apb(1'b1, 8'h34, 32'd12);
    cmd(32'h2C);
    ea[25] = 1'b0;
    chk(accumulator_two, ea);
    rdc(8'h34, 40'd12);
    cmd(32'h28);
    ea[10] = 1'b0;
    chk(accumulator_two, ea);
    rdc(8'h34, 40'd27);
    apb(1'b1, 8'h38, 32'h41);
    cmd(32'h34);
    ea[16] = 1'b0;
    chk(accumulator_two, ea);
    rdc(`RBA_ADDR_OFF, 40'h50);
    $display("test circular done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_post();
    t_index();
    t_circ();
    stop_test();
  end
endmodule // test_register_bit_address_generator
